// ---- dv/ctfi_far_model.sv ----
`timescale 1ns/100ps
module ctfi_far_model #(
  parameter logic [15:0] TB_BASE = 16'hc018,
  parameter logic [15:0] HR_BASE = 16'hc020,
  parameter logic [15:0] AD_BASE = 16'hc022,
  parameter logic [15:0] FL_SRC  = 16'h0723
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire ctfi_pkg::ctfi_rd_req_t rd_req,
  input  wire logic                   fire,
  input  wire logic [23:0]            cnt,
  input  wire logic [23:0]            lines,
  input  wire logic [23:0]            sin_v,
  input  wire logic [23:0]            cos_v,
  input  wire logic [23:0]            fl_in,
  output logic [23:0]                 rd_data,
  output logic                        cap_trig
);
  import ctfi_pkg::*;

  logic [23:0] last_q;
  logic [23:0] cap_q;
  logic        trig_q;

  // ****************************************
  // Read answer
  // ****************************************
  // Released bus shows the inverse of the last answer
  always_comb begin
    rd_data = ~last_q;
    if (rd_req.en) begin
      case (rd_req.addr)
        HR_BASE, HR_BASE + 16'h0001: rd_data = lines;
        AD_BASE:                     rd_data = sin_v;
        AD_BASE + 16'h0001:          rd_data = cos_v;
        TB_BASE:                     rd_data = cnt;
        TB_BASE + CAPT_OFS:          rd_data = cap_q;
        FL_SRC:                      rd_data = fl_in;
        default:                     rd_data = ~last_q;
      endcase
    end
  end

  // Remember last driven answer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_q <= 24'h000000;
    end else if (rd_req.en) begin
      last_q <= rd_data;
    end
  end

  // ****************************************
  // Capture trigger logic
  // ****************************************
  // read clears trigger
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_q <= 1'b0;
      cap_q  <= 24'h000000;
    end else if (fire) begin
      trig_q <= 1'b1;
      cap_q  <= cnt;
    end else if (rd_req.en && rd_req.addr == TB_BASE + CAPT_OFS) begin
      trig_q <= 1'b0;
    end
  end

  assign cap_trig = trig_q;
endmodule

// ---- dv/tb_conversion_table_tb_filter_interp.sv ----
`timescale 1ns/100ps
module tb_conversion_table_tb_filter_interp;
  import ctfi_pkg::*;

  localparam logic [15:0] TBB          = 16'hc018;
  localparam logic [15:0] HRB          = 16'hc020;
  localparam logic [15:0] ADB          = 16'hc022;
  localparam logic [15:0] FLS          = 16'h0723;
  localparam int          SCRIPT [12]  = '{0, 0, 1, 2, 3, 3, 0, 1, 1, 2, 3, 3};

  logic         ref_clk    = 1'b0;
  logic         sys_rst    = 1'b1;
  logic         servo_tick = 1'b0;
  logic         fire       = 1'b0;
  ctfi_cfg_t    cfg        = '0;
  logic [23:0]  cnt        = 24'h000000;
  logic [23:0]  lines      = 24'h000000;
  logic [23:0]  sin_v      = 24'h000000;
  logic [23:0]  cos_v      = 24'h000000;
  logic [23:0]  fl_in      = 24'h000000;
  ctfi_rd_req_t rd_req_q;
  logic         cap_trig;
  logic         cycle_done_q;
  logic [23:0]  rd_data;
  logic [23:0]  tb_word_q;
  logic [23:0]  tb_result_q;
  logic [23:0]  fl_result_q;
  logic [23:0]  hr_result_q;
  int           n_mismatch = 0;
  int           n_checks   = 0;
  logic [15:0]  rlog [$];

  // ****************************************
  // Clock, design and far side
  // ****************************************
  always #5 ref_clk = ~ref_clk;

  ctfi_table DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .servo_tick(servo_tick), .cfg(cfg),
    .cap_trig(cap_trig), .rd_data(rd_data), .rd_req_q(rd_req_q), .tb_word_q(tb_word_q),
    .tb_result_q(tb_result_q), .fl_result_q(fl_result_q), .hr_result_q(hr_result_q),
    .cycle_done_q(cycle_done_q));

  ctfi_far_model #(.TB_BASE(TBB), .HR_BASE(HRB), .AD_BASE(ADB), .FL_SRC(FLS)) far (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .rd_req(rd_req_q), .fire(fire), .cnt(cnt),
    .lines(lines), .sin_v(sin_v), .cos_v(cos_v), .fl_in(fl_in), .rd_data(rd_data),
    .cap_trig(cap_trig));

  // Log of read addresses in one pass
  always @(posedge ref_clk) begin
    if (rd_req_q.en === 1'b1) rlog.push_back(rd_req_q.addr);
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wcfg(input logic [2:0] s, input logic [23:0] d);
    @(negedge ref_clk);
    cfg = '{wr: 1'b1, sel: s, data: d};
    @(negedge ref_clk);
    cfg.wr = 1'b0;
  endtask

  function automatic int idx(input logic [15:0] a);
    foreach (rlog[i]) if (rlog[i] === a) return i;
    return -1;
  endfunction

  // Filter step with floor scaling and symmetric clamp
  function automatic logic [23:0] fl_exp(input logic [23:0] prev, input logic [23:0] in,
                                         input logic [23:0] k, input logic [23:0] mx);
    logic signed [23:0] d;
    logic signed [47:0] s;
    d = in - prev;
    s = (d * $signed(k)) >>> 23;
    if (s > $signed({24'h000000, mx})) s = $signed({24'h000000, mx});
    if (s < -$signed({24'h000000, mx})) s = -$signed({24'h000000, mx});
    return prev + s[23:0];
  endfunction

  task automatic run_pass(output int cyc);
    rlog.delete();
    @(negedge ref_clk);
    servo_tick = 1'b1;
    @(negedge ref_clk);
    servo_tick = 1'b0;
    cyc = 1;
    while (cycle_done_q !== 1'b1 && cyc < 80) begin
      @(negedge ref_clk);
      cyc++;
    end
    chk("pass_done", 24'h000001, {23'h000000, cycle_done_q});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int          cyc;
    int          code;
    logic [23:0] exp_fl;
    logic [23:0] refv;
    logic [23:0] sf;
    logic [23:0] gain;
    logic [23:0] mx;
    logic [23:0] hrw;
    logic [23:0] e;
    logic [15:0] hra;
    cyc = $urandom(73);
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("rst_tb_word", 24'h000000, tb_word_q);
    chk("rst_fl", 24'h000000, fl_result_q);
    chk("rst_hr", 24'h000000, hr_result_q);
    sf = 24'($urandom_range(1, 1023));
    wcfg(SEL_HR_AD, {8'h00, ADB});
    // stray second digit, source not the time-base channel
    wcfg(SEL_FL_WORD, {METH_FILTER, 4'h7, FLS});
    wcfg(SEL_TB_SF, sf);
    exp_fl = 24'h000000;
    refv = 24'h000000;
    for (int p = 0; p < 12; p++) begin
      hrw = {METH_HIRES, 1'($urandom_range(0, 1)), 3'h0, HRB};
      hra = hrw[STYLE_BIT] ? HRB + 16'h0001 : HRB;
      gain = 24'($urandom_range(1, 24'h7fffff));
      mx = (p % 3 == 0) ? 24'($urandom_range(0, 255)) : 24'($urandom_range(0, 24'h3fffff));
      wcfg(SEL_HR_WORD, hrw);
      wcfg(SEL_FL_GAIN, gain);
      wcfg(SEL_FL_MAX, mx);
      lines = 24'($urandom);
      sin_v = 24'($urandom);
      cos_v = 24'($urandom);
      fl_in = 24'($urandom);
      cnt = 24'($urandom);
      code = SCRIPT[p];
      if (code == 0) wcfg(SEL_TB_WORD, {METH_FROZEN, 4'h0, TBB});
      if (code == 1) wcfg(SEL_TB_WORD, {METH_ARMED, 4'h0, TBB});
      if (code == 2) begin
        fire = 1'b1;
        @(negedge ref_clk);
        fire = 1'b0;
        refv = cnt;
      end
      run_pass(cyc);
      chk("hr_lines", {12'h000, lines[11:0]}, {12'h000, hr_result_q[23:12]});
      chk("hr_quad", {22'h0, sin_v[23], sin_v[23] ^ cos_v[23]}, {22'h0, hr_result_q[11:10]});
      chk("hr_count_read", 24'h000001, 24'(idx(hra) >= 0));
      chk("ad_reads", 24'h000001, 24'(idx(ADB) >= 0 && idx(ADB + 16'h0001) > idx(ADB)));
      chk("order_hr_fl", 24'h000001, 24'(idx(hra) < idx(FLS)));
      exp_fl = fl_exp(exp_fl, fl_in, gain, mx);
      chk("fl_result", exp_fl, fl_result_q);
      case (code)
        0: begin
          chk("frozen_result", 24'h000000, tb_result_q);
          chk("frozen_capt_read", 24'h000001, 24'(idx(TBB + CAPT_OFS) > idx(FLS)));
          chk("frozen_word", {METH_FROZEN, 4'h0, TBB}, tb_word_q);
        end
        1: begin
          chk("armed_result", 24'h000000, tb_result_q);
          chk("armed_no_read", 24'h000001, 24'(idx(TBB + CAPT_OFS) < 0));
          chk("armed_word", {METH_ARMED, 4'h0, TBB}, tb_word_q);
        end
        2: begin
          chk("trig_word", {METH_RUNNING, 4'h0, TBB}, tb_word_q);
          chk("trig_capt_read", 24'h000001, 24'(idx(TBB + CAPT_OFS) >= 0));
        end
        default: begin
          e = (cnt - refv) * sf;
          e = e << TB_SHIFT;
          chk("run_result", e, tb_result_q);
          chk("run_count_read", 24'h000001, 24'(idx(TBB) > idx(FLS)));
          refv = cnt;
        end
      endcase
    end
    // Interpolator switched off: no read, result stands
    e = {12'h000, lines[11:0]};
    wcfg(SEL_HR_WORD, {4'h0, 4'h0, HRB});
    lines = 24'($urandom);
    run_pass(cyc);
    chk("hr_hold", e, {12'h000, hr_result_q[23:12]});
    chk("hr_off_no_read", 24'h000001, 24'(idx(HRB) < 0 && idx(ADB) < 0));
    chk("short_pass", 24'h000001, 24'(cyc < 12));
    close_out();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end
endmodule

// ---- rtl/ctfi_expfilt.sv ----
`timescale 1ns/100ps
module ctfi_expfilt (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [23:0] src,
  input  wire logic [23:0] gain,
  input  wire logic [23:0] max_change,
  output logic             done_q,
  output logic [23:0]      out_q
);
  import ctfi_pkg::*;

  logic signed [23:0] diff;
  logic signed [47:0] prod;
  logic signed [47:0] step_raw;
  logic signed [23:0] lim;
  logic signed [23:0] step;

  // ****************************************
  // Filter arithmetic
  // ****************************************
  // signed 24-bit wrap
  always_comb begin
    diff     = $signed(src - out_q);
    prod     = diff * $signed(gain);
    step_raw = prod >>> GAIN_SHIFT;
    lim      = $signed(max_change);
    if (step_raw > 48'(lim)) begin
      step = lim;
    end else if (step_raw < -48'(lim)) begin
      step = -lim;
    end else begin
      step = step_raw[23:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q  <= WORD_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= start;
      if (start) begin
        out_q <= out_q + step;
      end
    end
  end

  a_filter_clamp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_q |-> ($signed(out_q - $past(out_q)) <= $signed(max_change)) &&
               ($signed(out_q - $past(out_q)) >= -$signed(max_change)))
    else $error("filter step exceeds limit");

  c_filter_clamped: cover property (@(posedge ref_clk) disable iff (sys_rst)
    start && (step != step_raw[23:0]));

endmodule

// ---- rtl/ctfi_hrinterp.sv ----
`timescale 1ns/100ps
module ctfi_hrinterp (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [23:0] lines,
  input  wire logic [23:0] sin_ad,
  input  wire logic [23:0] cos_ad,
  output logic             done_q,
  output logic [23:0]      pos_q
);
  import ctfi_pkg::*;

  logic [23:0] abs_s;
  logic [23:0] abs_c;
  logic [25:0] rem_q;
  logic [24:0] den_q;
  logic [9:0]  quo_q;
  logic [3:0]  bit_q;
  logic [1:0]  quad_q;
  logic        busy_q;
  logic [11:0] line_q;
  logic [25:0] rem_sh;
  logic [9:0]  frac_lo;

  // Magnitudes of both converter readings
  always_comb begin
    abs_s   = sin_ad[23] ? 24'(-sin_ad) : sin_ad;
    abs_c   = cos_ad[23] ? 24'(-cos_ad) : cos_ad;
    rem_sh  = {rem_q[24:0], 1'b0};
    frac_lo = quad_q[0] ? ~quo_q : quo_q;
  end

  // ****************************************
  // Ratio divider, one quotient bit a cycle
  // ****************************************
  // merge lines with in-line angle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rem_q  <= 26'h0000000;
      den_q  <= 25'h0000000;
      quo_q  <= 10'h000;
      bit_q  <= 4'h0;
      quad_q <= 2'h0;
      busy_q <= 1'b0;
      line_q <= 12'h000;
    end else if (start) begin
      rem_q  <= {2'h0, abs_s};
      den_q  <= {1'b0, abs_s} + {1'b0, abs_c};
      quo_q  <= 10'h000;
      bit_q  <= 4'ha;
      quad_q <= {sin_ad[23], sin_ad[23] ^ cos_ad[23]};
      busy_q <= 1'b1;
      line_q <= lines[11:0];
    end else if (busy_q) begin
      // Last busy cycle only hands the full quotient over
      if (bit_q != 4'h0) begin
        if (rem_sh >= {1'b0, den_q} && den_q != 25'h0000000) begin
          rem_q <= rem_sh - {1'b0, den_q};
          quo_q <= {quo_q[8:0], 1'b1};
        end else begin
          rem_q <= rem_sh;
          quo_q <= {quo_q[8:0], 1'b0};
        end
        bit_q <= bit_q - 4'h1;
      end
      busy_q <= (bit_q != 4'h0);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_q  <= WORD_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && (bit_q == 4'h0);
      if (busy_q && bit_q == 4'h0) begin
        pos_q <= {line_q, quad_q, frac_lo};
      end
    end
  end

  a_hr_frac: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start |-> ##12 done_q && pos_q[23:FRAC_W] == $past(lines[11:0], 12))
    else $error("interpolator position wrong or late");

endmodule

// ---- rtl/ctfi_pkg.sv ----
package ctfi_pkg;

  // ****************************************
  // Entry codes and field layout
  // ****************************************
  localparam logic [3:0]  METH_FROZEN  = 4'h9;
  localparam logic [3:0]  METH_RUNNING = 4'ha;
  localparam logic [3:0]  METH_ARMED   = 4'hb;
  localparam logic [3:0]  METH_FILTER  = 4'hd;
  localparam logic [3:0]  METH_HIRES   = 4'hf;
  localparam int          METH_LSB     = 20;
  localparam int          STYLE_BIT    = 19;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 24;

  // ****************************************
  // Channel offsets and arithmetic constants
  // ****************************************
  localparam logic [15:0] CAPT_OFS     = 16'h0003;
  localparam logic [15:0] CNT_OFS_GEN1 = 16'h0000;
  localparam logic [15:0] CNT_OFS_GEN2 = 16'h0001;
  localparam logic [15:0] AD2_OFS      = 16'h0001;
  localparam int          GAIN_SHIFT   = 23;
  localparam int          TB_SHIFT     = 6;
  localparam int          FRAC_W       = 12;

  // ****************************************
  // Setup word select codes
  // ****************************************
  localparam logic [2:0]  SEL_TB_WORD  = 3'h0;
  localparam logic [2:0]  SEL_TB_SF    = 3'h1;
  localparam logic [2:0]  SEL_FL_WORD  = 3'h2;
  localparam logic [2:0]  SEL_FL_GAIN  = 3'h3;
  localparam logic [2:0]  SEL_FL_MAX   = 3'h4;
  localparam logic [2:0]  SEL_HR_WORD  = 3'h5;
  localparam logic [2:0]  SEL_HR_AD    = 3'h6;
  localparam logic [23:0] WORD_RST     = 24'h000000;

  // Read request toward the servo IC / converter space
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
  } ctfi_rd_req_t;

  // Setup write from software
  typedef struct packed {
    logic        wr;
    logic [2:0]  sel;
    logic [23:0] data;
  } ctfi_cfg_t;

endpackage

// ---- rtl/ctfi_table.sv ----
`timescale 1ns/100ps
module ctfi_table (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  servo_tick,
  input  wire ctfi_pkg::ctfi_cfg_t   cfg,
  input  wire logic                  cap_trig,
  input  wire logic [23:0]           rd_data,
  output ctfi_pkg::ctfi_rd_req_t     rd_req_q,
  output logic [23:0]                tb_word_q,
  output logic [23:0]                tb_result_q,
  output logic [23:0]                fl_result_q,
  output logic [23:0]                hr_result_q,
  output logic                       cycle_done_q
);
  import ctfi_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_HR_CNT, ST_HR_AD1, ST_HR_AD2, ST_HR_CALC,
    ST_FL_SRC, ST_FL_CALC, ST_TB_REQ, ST_TB_TAKE, ST_DONE
  } ctfi_state_t;

  ctfi_state_t  state_q;
  logic [23:0]  tb_sf_q;
  logic [23:0]  fl_word_q;
  logic [23:0]  fl_gain_q;
  logic [23:0]  fl_max_q;
  logic [23:0]  hr_word_q;
  logic [23:0]  hr_ad_q;
  logic [23:0]  hr_cnt_q;
  logic [23:0]  hr_sin_q;
  logic [23:0]  tb_prev_q;
  logic         tb_fire_q;
  logic         hr_start;
  logic         hr_done;
  logic [23:0]  hr_pos;
  logic         fl_start;
  logic         fl_done;
  logic [23:0]  fl_out;
  logic         run_set;
  logic [3:0]   tb_meth;
  logic [15:0]  tb_base;
  logic [15:0]  hr_cnt_addr;
  logic [23:0]  tb_delta;
  logic [47:0]  tb_prod;
  logic [23:0]  tb_run_val;

  // ****************************************
  // Field decode and time-base arithmetic
  // ****************************************
  always_comb begin
    tb_meth     = tb_word_q[METH_LSB +: 4];
    tb_base     = tb_word_q[ADDR_W-1:0];
    hr_cnt_addr = hr_word_q[ADDR_W-1:0] +
                  (hr_word_q[STYLE_BIT] ? CNT_OFS_GEN2 : CNT_OFS_GEN1);
    tb_delta    = rd_data - tb_prev_q;
    tb_prod     = $signed(tb_delta) * $signed(tb_sf_q);
    tb_run_val  = {tb_prod[DATA_W-TB_SHIFT-1:0], {TB_SHIFT{1'b0}}};
    hr_start    = (state_q == ST_HR_AD2);
    fl_start    = (state_q == ST_FL_SRC);
    run_set     = (state_q == ST_TB_TAKE) && (tb_meth == METH_ARMED) && tb_fire_q;
  end

  // ****************************************
  // Setup words
  // ****************************************
  // Software writes; the hardware rewrite wins a collision
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tb_word_q <= WORD_RST;
      tb_sf_q   <= WORD_RST;
      fl_word_q <= WORD_RST;
      fl_gain_q <= WORD_RST;
      fl_max_q  <= WORD_RST;
      hr_word_q <= WORD_RST;
      hr_ad_q   <= WORD_RST;
    end else begin
      // keep channel base, set running code
      if (run_set) begin
        tb_word_q[METH_LSB +: 4] <= METH_RUNNING;
      end else if (cfg.wr && cfg.sel == SEL_TB_WORD) begin
        tb_word_q <= cfg.data;
      end
      if (cfg.wr && cfg.sel == SEL_TB_SF) begin
        tb_sf_q <= cfg.data;
      end
      if (cfg.wr && cfg.sel == SEL_FL_WORD) begin
        fl_word_q <= cfg.data;
      end
      if (cfg.wr && cfg.sel == SEL_FL_GAIN) begin
        fl_gain_q <= cfg.data;
      end
      if (cfg.wr && cfg.sel == SEL_FL_MAX) begin
        fl_max_q <= cfg.data;
      end
      if (cfg.wr && cfg.sel == SEL_HR_WORD) begin
        hr_word_q <= cfg.data;
      end
      if (cfg.wr && cfg.sel == SEL_HR_AD) begin
        hr_ad_q <= cfg.data;
      end
    end
  end

  // ****************************************
  // Table sequencer
  // ****************************************
  // one pass per tick, table order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (servo_tick) begin
            state_q <= (hr_word_q[METH_LSB +: 4] == METH_HIRES) ? ST_HR_CNT : ST_FL_SRC;
          end
        end
        ST_HR_CNT:  state_q <= ST_HR_AD1;
        ST_HR_AD1:  state_q <= ST_HR_AD2;
        ST_HR_AD2:  state_q <= ST_HR_CALC;
        ST_HR_CALC: begin
          if (hr_done) begin
            state_q <= ST_FL_SRC;
          end
        end
        ST_FL_SRC:  state_q <= ST_FL_CALC;
        ST_FL_CALC: state_q <= ST_TB_REQ;
        ST_TB_REQ:  state_q <= ST_TB_TAKE;
        ST_TB_TAKE: state_q <= ST_DONE;
        default:    state_q <= ST_IDLE;
      endcase
    end
  end

  // Read requests, data taken while the request stands
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_req_q <= '0;
    end else begin
      rd_req_q.en <= 1'b0;
      if (state_q == ST_IDLE && servo_tick &&
          hr_word_q[METH_LSB +: 4] == METH_HIRES) begin
        rd_req_q <= '{en: 1'b1, addr: hr_cnt_addr};
      end else if (state_q == ST_HR_CNT) begin
        rd_req_q <= '{en: 1'b1, addr: hr_ad_q[ADDR_W-1:0]};
      end else if (state_q == ST_HR_AD1) begin
        rd_req_q <= '{en: 1'b1, addr: hr_ad_q[ADDR_W-1:0] + AD2_OFS};
      end else if ((state_q == ST_HR_CALC && hr_done) ||
                   (state_q == ST_IDLE && servo_tick &&
                    hr_word_q[METH_LSB +: 4] != METH_HIRES)) begin
        rd_req_q <= '{en: 1'b1, addr: fl_word_q[ADDR_W-1:0]};
      end else if (state_q == ST_TB_REQ) begin
        // captured read resets trigger, answer taken in the next state
        if (tb_meth == METH_FROZEN || tb_fire_q) begin
          rd_req_q <= '{en: 1'b1, addr: tb_base + CAPT_OFS};
        end else if (tb_meth == METH_RUNNING) begin
          rd_req_q <= '{en: 1'b1, addr: tb_base};
        end
      end
    end
  end

  // Interpolator samples
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hr_cnt_q <= WORD_RST;
      hr_sin_q <= WORD_RST;
    end else begin
      if (state_q == ST_HR_CNT) begin
        hr_cnt_q <= rd_data;
      end
      if (state_q == ST_HR_AD1) begin
        hr_sin_q <= rd_data;
      end
    end
  end

  // ****************************************
  // Triggered time base
  // ****************************************
  // trigger tested in armed state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tb_fire_q <= 1'b0;
    end else if (state_q == ST_FL_CALC) begin
      tb_fire_q <= (tb_meth == METH_ARMED) && cap_trig;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tb_result_q <= WORD_RST;
      tb_prev_q   <= WORD_RST;
    end else if (state_q == ST_TB_TAKE) begin
      if (tb_meth == METH_RUNNING) begin
        tb_result_q <= tb_run_val;
        tb_prev_q   <= rd_data;
      end else begin
        tb_result_q <= WORD_RST;
        if (run_set) begin
          tb_prev_q <= rd_data;
        end
      end
    end
  end

  // ****************************************
  // Results and completion
  // ****************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fl_result_q  <= WORD_RST;
      hr_result_q  <= WORD_RST;
      cycle_done_q <= 1'b0;
    end else begin
      cycle_done_q <= (state_q == ST_DONE);
      if (fl_done) begin
        fl_result_q <= fl_out;
      end
      if (hr_done) begin
        hr_result_q <= hr_pos;
      end
    end
  end

  ctfi_hrinterp u_hrinterp (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (hr_start),
    .lines   (hr_cnt_q),
    .sin_ad  (hr_sin_q),
    .cos_ad  (rd_data),
    .done_q  (hr_done),
    .pos_q   (hr_pos)
  );

  ctfi_expfilt u_expfilt (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .start      (fl_start),
    .src        (rd_data),
    .gain       (fl_gain_q),
    .max_change (fl_max_q),
    .done_q     (fl_done),
    .out_q      (fl_out)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_frozen_capread: assert property (
    (state_q == ST_TB_REQ && tb_meth == METH_FROZEN) |=>
      rd_req_q.en && rd_req_q.addr == tb_base + CAPT_OFS ##1 tb_result_q == 24'h000000)
    else $error("frozen entry missed capture read or zero");
  a_armed_zero: assert property (
    (state_q == ST_TB_TAKE && tb_meth == METH_ARMED) |=> tb_result_q == 24'h000000)
    else $error("armed result not zero");
  a_arm_to_run: assert property (
    (state_q == ST_FL_CALC && tb_meth == METH_ARMED && cap_trig) |=>
      ##1 (tb_word_q[23:20] == METH_ARMED) ##1 (tb_word_q[23:20] == METH_RUNNING))
    else $error("trigger did not start time base");
  a_run_reference: assert property (
    run_set |=> tb_prev_q == $past(rd_data) && tb_result_q == 24'h000000)
    else $error("time zero not taken from capture");
  a_run_result: assert property (
    (state_q == ST_TB_TAKE && tb_meth == METH_RUNNING) |=>
      tb_result_q[5:0] == 6'h00 &&
      tb_result_q == 24'(($past(rd_data) - $past(tb_prev_q)) * $past(tb_sf_q) * 24'h000040))
    else $error("running result wrong");
  a_base_kept: assert property (
    run_set |=> tb_word_q[19:0] == $past(tb_word_q[19:0]))
    else $error("channel address disturbed by rewrite");
  a_ad_pair: assert property (
    (state_q == ST_HR_CNT) |=> rd_req_q.addr == hr_ad_q[15:0] ##1
      rd_req_q.addr == hr_ad_q[15:0] + 16'h0001)
    else $error("converter addresses out of sequence");
  a_cycle_bound: assert property (
    (state_q == ST_IDLE && servo_tick) |-> ##[6:21] cycle_done_q)
    else $error("table pass did not finish");

  c_trig_start: cover property (run_set);
  c_run_pass: cover property (state_q == ST_TB_TAKE && tb_meth == METH_RUNNING);
  c_full_pass: cover property (hr_done ##[1:10] cycle_done_q);

endmodule
